// file: spsi_defs.svh
//
// What this block does
// - full-step moves get maximum current for the first n (0-7) steps
// - hold timeout counts full-step times, 1-31; software never programs zero
// - pwm frequency is the crystal clock divided by 256 times n
// - a divider setting of zero behaves as 256
// - pwm duty is never below n/64; n resets to zero
// - sense one polarity bit picks low-true (0) or high-true (1)
// - sense one level mode: state bit follows the asserted input directly
// - sense one edge mode: state bit latches until the status is read
// - sense one stop bit clear: command register untouched by the input
// - sense one stop bit set: assertion clears the command register
// - sense two polarity bit picks low-true (0) or high-true (1)
// - sense two has the same level and edge state-bit modes
// - sense two stop bit clear: scan stops after step-counter steps, advance excluded
// - step counter zero with auto stop: scan runs until command written zero
// - sense two stop bit set: assertion stops scan or forward after counted steps
// - sense two never stops a rapid reverse move
`ifndef SPSI_DEFS_SVH
`define SPSI_DEFS_SVH

// ---------------------------------------------------------------
// register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define SPSI_IDX_CMD      8'h07
`define SPSI_IDX_STEP_LO  8'h4c
`define SPSI_IDX_STEP_HI  8'h4d
`define SPSI_IDX_KICK     8'h54
`define SPSI_IDX_HOLD     8'h55
`define SPSI_IDX_PWM_DIV  8'h56
`define SPSI_IDX_PWM_DUTY 8'h57
`define SPSI_IDX_SENSE    8'h58
`define SPSI_IDX_STATUS   8'h60
`define SPSI_IDX_INT_ST   8'h61
`define SPSI_IDX_INT_MASK 8'h62

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define SPSI_CMD_SCAN    0
`define SPSI_CMD_FWD     1
`define SPSI_CMD_REV     2
`define SPSI_SNS_POL1    0
`define SPSI_SNS_EDGE1   1
`define SPSI_SNS_STOP1   2
`define SPSI_SNS_POL2    3
`define SPSI_SNS_EDGE2   4
`define SPSI_SNS_STOP2   5
`define SPSI_EV_SENSE1   0
`define SPSI_EV_SENSE2   1
`define SPSI_EV_STOPPED  2

// ---------------------------------------------------------------
// reset values and constants
// ---------------------------------------------------------------
`define SPSI_RST_HOLD    5'h01
`define SPSI_RST_DIV     8'h01
`define SPSI_RST_DUTY    6'h00
`define SPSI_RST_KICK    3'h0
`define SPSI_RST_SENSE   6'h00
`define SPSI_RST_SYNC    2'b11
`define SPSI_KICK_MAX    3'h7
`define SPSI_DIV_ZERO    9'h100

`endif

// file: spsi_far_model.sv
`timescale 1ns/1ps

module spsi_far_model (
  // clock
  input  wire logic pclk,
  // sensors and step sequencer
  output logic      sense_input_one,
  output logic      sense_input_two,
  output logic      full_step,
  output logic      step_time_tick,
  output logic      initial_rapid_advance
);
  // ---------------------------------------------------------------
  // sensors idle low-true inactive, sequencer quiet
  // ---------------------------------------------------------------
  initial begin
    sense_input_one       = 1'b1;
    sense_input_two       = 1'b1;
    full_step             = 1'b0;
    step_time_tick        = 1'b0;
    initial_rapid_advance = 1'b0;
  end

  // pin level for an asserted state under a polarity
  task automatic sensor(input int which, input logic on, input logic pol);
    @(posedge pclk);
    if (which == 0) begin
      sense_input_one <= on ~^ pol;
    end else begin
      sense_input_two <= on ~^ pol;
    end
  endtask

  // steps spaced four cycles; adv marks the uncounted advance phase
  task automatic steps(input int n, input logic adv);
    repeat (n) begin
      @(posedge pclk);
      full_step             <= 1'b1;
      initial_rapid_advance <= adv;
      @(posedge pclk);
      full_step <= 1'b0;
      repeat (2) @(posedge pclk);
    end
    initial_rapid_advance <= 1'b0;
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge pclk);
      step_time_tick <= 1'b1;
      @(posedge pclk);
      step_time_tick <= 1'b0;
    end
  endtask
endmodule

// file: spsi_motor_sense.sv
// Local design decision: register access over APB.
`timescale 1ns/1ps
`include "spsi_defs.svh"

module spsi_motor_sense (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // sensors and step sequencer
  input  wire logic        sense_input_one,
  input  wire logic        sense_input_two,
  input  wire logic        full_step,
  input  wire logic        step_time_tick,
  input  wire logic        initial_rapid_advance,
  input  wire logic [5:0]  duty_request,
  // motor drive and command
  output logic             pwm_out,
  output logic             full_current,
  output logic             hold_current,
  output logic             scan_active,
  output logic             rapid_forward,
  output logic             rapid_reverse,
  output logic             irq
);

  spsi_pkg::spsi_state_t s;
  spsi_pkg::spsi_state_t next_s;

  logic       asrt1;
  logic       asrt2;
  logic       rise1;
  logic       rise2;
  logic       setup;
  logic       wr;
  logic       rd;
  logic [7:0] idx;
  logic       stop_one;
  logic       stop_two;
  logic       counting;
  logic [8:0] presc_last;
  logic [5:0] duty_eff;

  // ---------------------------------------------------------------
  // combinational helpers
  // ---------------------------------------------------------------
  always_comb begin
    idx   = paddr[9:2];
    setup = psel & ~penable;
    wr    = psel & penable & s.pready & pwrite;
    rd    = psel & penable & s.pready & ~pwrite;
    // polarity applied only to the second synchroniser stage
    asrt1 = s.sync1[1] ~^ s.sense_cfg[`SPSI_SNS_POL1];
    asrt2 = s.sync2[1] ~^ s.sense_cfg[`SPSI_SNS_POL2];
    rise1 = asrt1 & ~s.prev1;
    rise2 = asrt2 & ~s.prev2;
    stop_one = rise1 & s.sense_cfg[`SPSI_SNS_STOP1];
    // advance steps are not part of the counted distance
    counting = full_step & ~initial_rapid_advance &
               (s.cmd[`SPSI_CMD_SCAN] | s.cmd[`SPSI_CMD_FWD]);
    stop_two = 1'b0;
    if (s.step_cnt != 16'h0000) begin
      if (!s.sense_cfg[`SPSI_SNS_STOP2]) begin
        // auto stop applies to scans only
        stop_two = s.cmd[`SPSI_CMD_SCAN] & counting &
                   (s.steps_taken + 16'h0001 >= s.step_cnt);
      end else begin
        stop_two = s.armed2 & counting &
                   (s.steps_taken + 16'h0001 >= s.step_cnt);
      end
    end else if (s.sense_cfg[`SPSI_SNS_STOP2]) begin
      stop_two = rise2 & (s.cmd[`SPSI_CMD_SCAN] | s.cmd[`SPSI_CMD_FWD]);
    end
    presc_last = ((s.div == 8'h00) ? `SPSI_DIV_ZERO : {1'b0, s.div}) - 9'h001;
    duty_eff   = (duty_request > s.duty_min) ? duty_request : s.duty_min;
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.sync1 = {s.sync1[0], sense_input_one};
    next_s.sync2 = {s.sync2[0], sense_input_two};
    next_s.prev1 = asrt1;
    next_s.prev2 = asrt2;

    // apb answer: one wait-free access phase after every setup
    next_s.pready  = setup;
    next_s.pslverr = 1'b0;
    if (setup) begin
      next_s.prdata = 32'h0000_0000;
      case (idx)
        `SPSI_IDX_CMD:      next_s.prdata[2:0]  = s.cmd;
        `SPSI_IDX_STEP_LO:  next_s.prdata[7:0]  = s.step_cnt[7:0];
        `SPSI_IDX_STEP_HI:  next_s.prdata[7:0]  = s.step_cnt[15:8];
        `SPSI_IDX_KICK:     next_s.prdata[2:0]  = s.kick;
        `SPSI_IDX_HOLD:     next_s.prdata[7:3]  = s.hold_tmo;
        `SPSI_IDX_PWM_DIV:  next_s.prdata[7:0]  = s.div;
        `SPSI_IDX_PWM_DUTY: next_s.prdata[5:0]  = s.duty_min;
        `SPSI_IDX_SENSE:    next_s.prdata[5:0]  = s.sense_cfg;
        `SPSI_IDX_STATUS:   next_s.prdata[1:0]  = {s.st2, s.st1};
        `SPSI_IDX_INT_ST:   next_s.prdata[2:0]  = s.int_st;
        `SPSI_IDX_INT_MASK: next_s.prdata[2:0]  = s.int_mask;
        default:            next_s.pslverr      = 1'b1;
      endcase
    end

    // state bits: a status read clears edge latches, a new assertion wins
    if (s.sense_cfg[`SPSI_SNS_EDGE1]) begin
      next_s.st1 = (s.st1 & ~(rd && idx == `SPSI_IDX_STATUS)) | asrt1;
    end else begin
      next_s.st1 = asrt1;
    end
    if (s.sense_cfg[`SPSI_SNS_EDGE2]) begin
      next_s.st2 = (s.st2 & ~(rd && idx == `SPSI_IDX_STATUS)) | asrt2;
    end else begin
      next_s.st2 = asrt2;
    end

    // register writes
    if (wr) begin
      case (idx)
        `SPSI_IDX_CMD:      next_s.cmd       = pwdata[2:0];
        `SPSI_IDX_STEP_LO:  next_s.step_cnt[7:0]  = pwdata[7:0];
        `SPSI_IDX_STEP_HI:  next_s.step_cnt[15:8] = pwdata[7:0];
        `SPSI_IDX_KICK:     next_s.kick      = pwdata[2:0];
        `SPSI_IDX_HOLD:     next_s.hold_tmo  = pwdata[7:3];
        `SPSI_IDX_PWM_DIV:  next_s.div       = pwdata[7:0];
        `SPSI_IDX_PWM_DUTY: next_s.duty_min  = pwdata[5:0];
        `SPSI_IDX_SENSE:    next_s.sense_cfg = pwdata[5:0];
        `SPSI_IDX_INT_ST:   next_s.int_st    = s.int_st & ~pwdata[2:0];
        `SPSI_IDX_INT_MASK: next_s.int_mask  = pwdata[2:0];
        default:            next_s.cmd       = s.cmd;
      endcase
    end

    // step accounting for the current move
    if (s.cmd == 3'b000) begin
      next_s.steps_taken = 16'h0000;
      next_s.armed2      = 1'b0;
    end else if (counting && (!s.sense_cfg[`SPSI_SNS_STOP2] || s.armed2)) begin
      next_s.steps_taken = s.steps_taken + 16'h0001;
    end
    if (rise2 && s.sense_cfg[`SPSI_SNS_STOP2] && s.cmd != 3'b000 && !s.armed2) begin
      next_s.armed2      = 1'b1;
      next_s.steps_taken = 16'h0000;
    end

    // hardware stops win over a same-cycle software write
    if (stop_one) begin
      next_s.cmd = 3'b000;
    end else if (stop_two) begin
      // a reverse move is never stopped by sense two
      next_s.cmd = s.cmd & 3'b100;
    end
    // without its stop bit, sense one leaves the command alone

    // kickstart and hold-current timing
    if (s.cmd == 3'b000) begin
      next_s.kick_cnt = 3'h0;
    end else if (full_step && s.kick_cnt != `SPSI_KICK_MAX) begin
      next_s.kick_cnt = s.kick_cnt + 3'h1;
    end
    next_s.full_cur = (next_s.cmd != 3'b000) && (next_s.kick_cnt < next_s.kick);
    if (full_step) begin
      next_s.idle_cnt = 5'h00;
    end else if (step_time_tick && s.idle_cnt < s.hold_tmo) begin
      next_s.idle_cnt = s.idle_cnt + 5'h01;
    end
    next_s.hold_cur = (s.hold_tmo != 5'h00) && (next_s.idle_cnt >= s.hold_tmo);

    // pwm: period is 256 phase steps of (n or 256) crystal cycles
    if (s.presc >= presc_last) begin
      next_s.presc = 9'h000;
      next_s.phase = s.phase + 8'h01;
    end else begin
      next_s.presc = s.presc + 9'h001;
    end
    // full current overrides the duty request during kickstart
    next_s.pwm = s.full_cur | (next_s.phase[7:2] < duty_eff);

    // interrupts: set wins over clear
    if (rise1) next_s.int_st[`SPSI_EV_SENSE1] = 1'b1;
    if (rise2) next_s.int_st[`SPSI_EV_SENSE2] = 1'b1;
    if ((stop_one || stop_two) && s.cmd != 3'b000 && (next_s.cmd != s.cmd)) begin
      next_s.int_st[`SPSI_EV_STOPPED] = 1'b1;
    end
    next_s.irq = |(next_s.int_st & next_s.int_mask);
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s           <= '0;
      // idle high: with the default low-true polarity no false edge follows reset
      s.sync1     <= `SPSI_RST_SYNC;
      s.sync2     <= `SPSI_RST_SYNC;
      s.hold_tmo  <= `SPSI_RST_HOLD;
      s.div       <= `SPSI_RST_DIV;
      s.duty_min  <= `SPSI_RST_DUTY;
      s.kick      <= `SPSI_RST_KICK;
      s.sense_cfg <= `SPSI_RST_SENSE;
    end else begin
      s <= next_s;
    end
  end

  assign prdata        = s.prdata;
  assign pready        = s.pready;
  assign pslverr       = s.pslverr;
  assign pwm_out       = s.pwm;
  assign full_current  = s.full_cur;
  assign hold_current  = s.hold_cur;
  assign scan_active   = s.cmd[`SPSI_CMD_SCAN];
  assign rapid_forward = s.cmd[`SPSI_CMD_FWD];
  assign rapid_reverse = s.cmd[`SPSI_CMD_REV];
  assign irq           = s.irq;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence q_step_seen;
    full_step ##1 1'b1;
  endsequence

  property p_kick_limit;
    @(posedge pclk) disable iff (!presetn)
      s.full_cur |-> (s.kick_cnt < s.kick) && (s.cmd != 3'b000);
  endproperty
  a_kick_limit: assert property (p_kick_limit) else $error("full current past kickstart");

  property p_hold_after_step;
    @(posedge pclk) disable iff (!presetn)
      q_step_seen |-> !s.hold_cur;
  endproperty
  a_hold_after_step: assert property (p_hold_after_step) else $error("hold right after step");

  property p_pwm_rate;
    @(posedge pclk) disable iff (!presetn)
      (s.presc < presc_last) |=> $stable(s.phase);
  endproperty
  a_pwm_rate: assert property (p_pwm_rate) else $error("phase moved early");

  property p_div_zero;
    @(posedge pclk) disable iff (!presetn)
      (s.div == 8'h00 && s.presc == 9'h0fe && !wr) |=> (s.presc == 9'h0ff) ##1 (s.presc == 9'h000);
  endproperty
  a_div_zero: assert property (p_div_zero) else $error("zero divider not 256");

  property p_min_duty;
    @(posedge pclk) disable iff (!presetn)
      (s.phase[7:2] < s.duty_min && $stable(s.duty_min)) |-> s.pwm;
  endproperty
  a_min_duty: assert property (p_min_duty) else $error("duty under minimum");

  property p_level1;
    @(posedge pclk) disable iff (!presetn)
      !s.sense_cfg[`SPSI_SNS_EDGE1] |=> (s.st1 == $past(asrt1));
  endproperty
  a_level1: assert property (p_level1) else $error("level state bit wrong");

  property p_edge1;
    @(posedge pclk) disable iff (!presetn)
      (s.sense_cfg[`SPSI_SNS_EDGE1] && s.st1 && !(rd && idx == `SPSI_IDX_STATUS)) |=> s.st1;
  endproperty
  a_edge1: assert property (p_edge1) else $error("edge state bit lost");

  property p_stop1;
    @(posedge pclk) disable iff (!presetn)
      stop_one |=> (s.cmd == 3'b000);
  endproperty
  a_stop1: assert property (p_stop1) else $error("sense one did not stop");

  property p_no_stop1;
    @(posedge pclk) disable iff (!presetn)
      (rise1 && !s.sense_cfg[`SPSI_SNS_STOP1] && !wr && !stop_two) |=> $stable(s.cmd);
  endproperty
  a_no_stop1: assert property (p_no_stop1) else $error("sense one changed command");

  property p_rev_kept;
    @(posedge pclk) disable iff (!presetn)
      (s.cmd[`SPSI_CMD_REV] && !wr && !stop_one) |=> s.cmd[`SPSI_CMD_REV];
  endproperty
  a_rev_kept: assert property (p_rev_kept) else $error("reverse stopped");

  property p_sync_delay;
    @(posedge pclk) disable iff (!presetn)
      (sense_input_one && !s.sense_cfg[`SPSI_SNS_EDGE1]) ##1 sense_input_one |=>
        (s.sync1[1] == 1'b1);
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("synchroniser wrong");

  // ---------------------------------------------------------------
  // polarity, sense state, stop interrupt, pwm phase, step counter and current checks
  // ---------------------------------------------------------------
  property p_pol1;
    @(posedge pclk) disable iff (!presetn)
      (s.sync1[1] == s.sense_cfg[`SPSI_SNS_POL1] && !s.sense_cfg[`SPSI_SNS_EDGE1]) |=> s.st1;
  endproperty
  a_pol1: assert property (p_pol1) else $error("polarity one wrong");

  property p_pol2;
    @(posedge pclk) disable iff (!presetn)
      (s.sync2[1] == s.sense_cfg[`SPSI_SNS_POL2] && !s.sense_cfg[`SPSI_SNS_EDGE2]) |=> s.st2;
  endproperty
  a_pol2: assert property (p_pol2) else $error("polarity two wrong");

  property p_level2;
    @(posedge pclk) disable iff (!presetn)
      !s.sense_cfg[`SPSI_SNS_EDGE2] |=> (s.st2 == $past(asrt2));
  endproperty
  a_level2: assert property (p_level2) else $error("level state two wrong");

  property p_edge2;
    @(posedge pclk) disable iff (!presetn)
      (s.sense_cfg[`SPSI_SNS_EDGE2] && s.st2 && !(rd && idx == `SPSI_IDX_STATUS)) |=> s.st2;
  endproperty
  a_edge2: assert property (p_edge2) else $error("edge state two lost");

  property p_edge_set;
    @(posedge pclk) disable iff (!presetn)
      (s.sense_cfg[`SPSI_SNS_EDGE1] && asrt1) |=> s.st1;
  endproperty
  a_edge_set: assert property (p_edge_set) else $error("edge state not set");

  property p_stop_irq;
    @(posedge pclk) disable iff (!presetn)
      (stop_one && s.cmd != 3'b000) |=> s.int_st[`SPSI_EV_STOPPED];
  endproperty
  a_stop_irq: assert property (p_stop_irq) else $error("stop event lost");

  property p_phase_step;
    @(posedge pclk) disable iff (!presetn)
      (s.presc >= presc_last) |=> (s.phase == $past(s.phase) + 8'h01);
  endproperty
  a_phase_step: assert property (p_phase_step) else $error("phase did not step");

  property p_auto_stop;
    @(posedge pclk) disable iff (!presetn)
      (!s.sense_cfg[`SPSI_SNS_STOP2] && s.cmd[`SPSI_CMD_SCAN] && full_step &&
       !initial_rapid_advance && s.step_cnt != 16'h0000 &&
       (s.steps_taken + 16'h0001 == s.step_cnt)) |=> !s.cmd[`SPSI_CMD_SCAN];
  endproperty
  a_auto_stop: assert property (p_auto_stop) else $error("scan not stopped");

  property p_no_auto_stop;
    @(posedge pclk) disable iff (!presetn)
      (s.step_cnt == 16'h0000 && !s.sense_cfg[`SPSI_SNS_STOP2] && s.cmd[`SPSI_CMD_SCAN] &&
       !wr && !stop_one) |=> s.cmd[`SPSI_CMD_SCAN];
  endproperty
  a_no_auto_stop: assert property (p_no_auto_stop) else $error("zero count stop");

  property p_sense_stop;
    @(posedge pclk) disable iff (!presetn)
      (s.sense_cfg[`SPSI_SNS_STOP2] && s.armed2 && full_step && !initial_rapid_advance &&
       s.step_cnt != 16'h0000 && (s.steps_taken + 16'h0001 == s.step_cnt) &&
       (s.cmd[`SPSI_CMD_SCAN] || s.cmd[`SPSI_CMD_FWD])) |=>
        (!s.cmd[`SPSI_CMD_SCAN] && !s.cmd[`SPSI_CMD_FWD]);
  endproperty
  a_sense_stop: assert property (p_sense_stop) else $error("sense two no stop");

  property p_kick_on;
    @(posedge pclk) disable iff (!presetn)
      (s.cmd != 3'b000 && s.kick_cnt == 3'h0 && s.kick != 3'h0 && !full_step && !wr &&
       !stop_one && !stop_two) |=> s.full_cur;
  endproperty
  a_kick_on: assert property (p_kick_on) else $error("no kickstart");

  property p_hold_reach;
    @(posedge pclk) disable iff (!presetn)
      (step_time_tick && !full_step && s.hold_tmo != 5'h00 &&
       (s.idle_cnt + 5'h01 == s.hold_tmo)) |=> s.hold_cur;
  endproperty
  a_hold_reach: assert property (p_hold_reach) else $error("hold not reached");

endmodule

// file: spsi_pkg.sv
package spsi_pkg;

  typedef struct packed {
    logic [1:0]  sync1;
    logic [1:0]  sync2;
    logic        prev1;
    logic        prev2;
    logic        st1;
    logic        st2;
    logic [2:0]  kick;
    logic [4:0]  hold_tmo;
    logic [7:0]  div;
    logic [5:0]  duty_min;
    logic [5:0]  sense_cfg;
    logic [2:0]  cmd;
    logic [15:0] step_cnt;
    logic [15:0] steps_taken;
    logic        armed2;
    logic [2:0]  kick_cnt;
    logic [4:0]  idle_cnt;
    logic [8:0]  presc;
    logic [7:0]  phase;
    logic        pwm;
    logic        full_cur;
    logic        hold_cur;
    logic [2:0]  int_st;
    logic [2:0]  int_mask;
    logic        irq;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } spsi_state_t;

endpackage

// file: testbench.sv
`timescale 1ns/1ps
`include "spsi_defs.svh"

module testbench;
  logic        pclk, presetn, psel, penable, pwrite, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, s1, s2, fstep, tick, adv;
  logic [5:0]  duty_request;
  logic        pwm_out, full_current, hold_current, irq, scan, fwd, rev;
  int          mismatches, checks, hi, per;
  logic [7:0]  ridx[4] = '{`SPSI_IDX_HOLD, `SPSI_IDX_PWM_DIV, `SPSI_IDX_PWM_DUTY, `SPSI_IDX_SENSE};
  logic [31:0] rval[4] = '{32'hf8, 32'h00, 32'h3f, 32'h3f};
  int          pdiv[2] = '{2, 1};
  int          pmin[2] = '{16, 1};
  int          preq[2] = '{0, 8};

  always #12.5 pclk = ~pclk;

  spsi_motor_sense spsi_motor_sense_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sense_input_one(s1), .sense_input_two(s2),
    .full_step(fstep), .step_time_tick(tick), .initial_rapid_advance(adv),
    .duty_request(duty_request), .pwm_out(pwm_out), .full_current(full_current),
    .hold_current(hold_current), .scan_active(scan), .rapid_forward(fwd), .rapid_reverse(rev),
    .irq(irq));

  // home sensor wired to sense one, as a flatbed would be
  spsi_far_model spsi_far_model_i (.pclk(pclk), .sense_input_one(s1), .sense_input_two(s2),
    .full_step(fstep), .step_time_tick(tick), .initial_rapid_advance(adv));

  // ---------------------------------------------------------------
  // bus and compare tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'h0, idx, 2'h0};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic results;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    cyc(20000);
    mismatches++;
    results();
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    duty_request = 6'h00;
    cyc(6);
    presetn <= 1'b1;
    rdchk(`SPSI_IDX_PWM_DUTY, 32'h0);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, ridx[i], rval[i]);
      rdchk(ridx[i], rval[i]);
    end
    apb(1'b0, 8'h30, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    $display("test registers done");
    for (int i = 0; i < 2; i++) begin
      for (int p = 0; p < 2; p++) begin
        apb(1'b1, `SPSI_IDX_SENSE, 32'(p) << (3 * i));
        spsi_far_model_i.sensor(i, 1'b1, p[0]);
        cyc(5);
        rdchk(`SPSI_IDX_STATUS, 32'h1 << i);
        spsi_far_model_i.sensor(i, 1'b0, p[0]);
        cyc(5);
        rdchk(`SPSI_IDX_STATUS, 32'h0);
      end
      apb(1'b1, `SPSI_IDX_SENSE, 32'h3 << (3 * i));
      spsi_far_model_i.sensor(i, 1'b1, 1'b1);
      cyc(3);
      spsi_far_model_i.sensor(i, 1'b0, 1'b1);
      cyc(5);
      rdchk(`SPSI_IDX_STATUS, 32'h1 << i);
      rdchk(`SPSI_IDX_STATUS, 32'h0);
      apb(1'b1, `SPSI_IDX_SENSE, 32'h0);
      spsi_far_model_i.sensor(i, 1'b0, 1'b0);
    end
    $display("test sense modes done");
    spsi_far_model_i.sensor(0, 1'b0, 1'b1);
    apb(1'b1, `SPSI_IDX_SENSE, 32'h01);
    apb(1'b1, `SPSI_IDX_INT_MASK, 32'h1);
    apb(1'b1, `SPSI_IDX_INT_ST, 32'h7);
    apb(1'b1, `SPSI_IDX_CMD, 32'h1);
    spsi_far_model_i.sensor(0, 1'b1, 1'b1);
    cyc(5);
    rdchk(`SPSI_IDX_CMD, 32'h1);
    chk({29'h0, rev, fwd, scan}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, `SPSI_IDX_INT_ST, 32'h1);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, `SPSI_IDX_SENSE, 32'h05);
    for (int k = 0; k < 3; k++) begin
      spsi_far_model_i.sensor(0, 1'b0, 1'b1);
      apb(1'b1, `SPSI_IDX_CMD, 32'h1 << k);
      spsi_far_model_i.sensor(0, 1'b1, 1'b1);
      cyc(5);
      rdchk(`SPSI_IDX_CMD, 32'h0);
      chk({29'h0, rev, fwd, scan}, 32'h0);
    end
    apb(1'b1, `SPSI_IDX_SENSE, 32'h0);
    spsi_far_model_i.sensor(0, 1'b0, 1'b0);
    $display("test sense stop done");
    apb(1'b1, `SPSI_IDX_STEP_LO, 32'h3);
    apb(1'b1, `SPSI_IDX_CMD, 32'h1);
    spsi_far_model_i.steps(2, 1'b1);
    spsi_far_model_i.steps(2, 1'b0);
    rdchk(`SPSI_IDX_CMD, 32'h1);
    spsi_far_model_i.steps(1, 1'b0);
    rdchk(`SPSI_IDX_CMD, 32'h0);
    apb(1'b1, `SPSI_IDX_STEP_LO, 32'h0);
    apb(1'b1, `SPSI_IDX_KICK, 32'h2);
    apb(1'b1, `SPSI_IDX_CMD, 32'h1);
    cyc(2);
    chk({31'h0, full_current}, 32'h1);
    spsi_far_model_i.steps(1, 1'b0);
    chk({31'h0, full_current}, 32'h1);
    spsi_far_model_i.steps(1, 1'b0);
    chk({31'h0, full_current}, 32'h0);
    spsi_far_model_i.steps(3, 1'b0);
    rdchk(`SPSI_IDX_CMD, 32'h1);
    apb(1'b1, `SPSI_IDX_CMD, 32'h0);
    rdchk(`SPSI_IDX_CMD, 32'h0);
    apb(1'b1, `SPSI_IDX_HOLD, 32'h18);
    spsi_far_model_i.steps(1, 1'b0);
    spsi_far_model_i.ticks(2);
    cyc(2);
    chk({31'h0, hold_current}, 32'h0);
    spsi_far_model_i.ticks(1);
    cyc(2);
    chk({31'h0, hold_current}, 32'h1);
    $display("test step count done");
    apb(1'b1, `SPSI_IDX_STEP_LO, 32'h2);
    spsi_far_model_i.sensor(1, 1'b0, 1'b1);
    apb(1'b1, `SPSI_IDX_SENSE, 32'h28);
    apb(1'b1, `SPSI_IDX_CMD, 32'h2);
    spsi_far_model_i.steps(3, 1'b0);
    spsi_far_model_i.sensor(1, 1'b1, 1'b1);
    cyc(5);
    spsi_far_model_i.steps(1, 1'b0);
    rdchk(`SPSI_IDX_CMD, 32'h2);
    chk({29'h0, rev, fwd, scan}, 32'h2);
    spsi_far_model_i.steps(1, 1'b0);
    rdchk(`SPSI_IDX_CMD, 32'h0);
    spsi_far_model_i.sensor(1, 1'b0, 1'b1);
    apb(1'b1, `SPSI_IDX_CMD, 32'h4);
    spsi_far_model_i.sensor(1, 1'b1, 1'b1);
    cyc(5);
    spsi_far_model_i.steps(3, 1'b0);
    rdchk(`SPSI_IDX_CMD, 32'h4);
    chk({29'h0, rev, fwd, scan}, 32'h4);
    apb(1'b1, `SPSI_IDX_CMD, 32'h0);
    $display("test sense two stop done");
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, `SPSI_IDX_PWM_DIV, 32'(pdiv[i]));
      apb(1'b1, `SPSI_IDX_PWM_DUTY, 32'(pmin[i]));
      duty_request <= 6'(preq[i]);
      hi = 0;
      while (pwm_out !== 1'b0 && hi < 2000) begin
        cyc(1);
        hi++;
      end
      while (pwm_out !== 1'b1 && hi < 4000) begin
        cyc(1);
        hi++;
      end
      hi = 0;
      while (pwm_out === 1'b1 && hi < 2000) begin
        cyc(1);
        hi++;
      end
      per = hi;
      while (pwm_out !== 1'b1 && per < 2000) begin
        cyc(1);
        per++;
      end
      chk(32'(hi), 32'(((pmin[i] > preq[i]) ? pmin[i] : preq[i]) * 4 * pdiv[i]));
      chk(32'(per), 32'(256 * pdiv[i]));
    end
    $display("test pwm done");
    results();
  end
endmodule
